// file: hdl/ecfd_consts.svh
// Constants for the event counter and frequency divider channel.
`ifndef ECFD_CONSTS_SVH
`define ECFD_CONSTS_SVH

`define ECFD_CNT_W          16
`define ECFD_CNT_ZERO       16'h0000
`define ECFD_RELOAD_RST     16'h0000
`define ECFD_PRESCALE_W     4
`define ECFD_PRESCALE_RST   8'h00
`define ECFD_DIV_CH_A       2'h0
`define ECFD_DIV_CH_B       2'h3
`define ECFD_EDGE_FALL      2'h0
`define ECFD_EDGE_RISE      2'h1
`define ECFD_EDGE_BOTH      2'h2
`define ECFD_FILTER_LEN     3

`endif

// file: hdl/ecfd_pkg.sv
// Types shared by the event counter and frequency divider channel.
`default_nettype none
package ecfd_pkg;

    typedef enum logic [1:0]
    {
        ECFD_MODE_EVENT   = 2'h1,
        ECFD_MODE_DIVIDER = 2'h2
    } ecfd_mode_t;

    typedef struct packed
    {
        ecfd_mode_t  mode;
        logic        clk_sel;
        logic [1:0]  edge_sel;
        logic        start_irq_select;
        logic        split_high;
    } ecfd_cfg_t;

    typedef enum logic [2:0]
    {
        ECFD_ST_IDLE  = 3'b001,
        ECFD_ST_ARMED = 3'b010,
        ECFD_ST_RUN   = 3'b100
    } ecfd_state_t;

endpackage : ecfd_pkg
`default_nettype wire

// file: hdl/ecfd_edge_detect.sv
// Input synchroniser, optional noise filter and valid edge detector.
`default_nettype none
`include "ecfd_consts.svh"
module ecfd_edge_detect
    import ecfd_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_clr,
    input  wire logic       i_tick,
    input  wire logic       i_filter_en,
    input  wire logic [1:0] i_edge_sel,
    input  wire logic       i_pin,
    output logic            o_edge
);

    logic                          sync1_q;
    logic                          sync2_q;
    logic [`ECFD_FILTER_LEN-1:0]   shift_q;
    logic                          level_q;
    logic                          prev_q;
    logic                          level_d;

    // ----------------------------------------------------------------
    // Synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end
        else
        begin
            sync1_q <= i_pin;
            sync2_q <= sync1_q;
        end
    end

    // ----------------------------------------------------------------
    // Sampling on the operating clock tick
    // ----------------------------------------------------------------
    // With the filter on, a level counts only once it held for every sample.
    always_comb
    begin
        level_d = level_q;
        if (!i_filter_en)
            level_d = shift_q[0];
        else if (&shift_q)
            level_d = 1'b1;
        else if (~|shift_q)
            level_d = 1'b0;
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            shift_q <= '0;
            level_q <= 1'b0;
            prev_q  <= 1'b0;
            o_edge  <= 1'b0;
        end
        else if (i_clr)
        begin
            shift_q <= '0;
            level_q <= 1'b0;
            prev_q  <= 1'b0;
            o_edge  <= 1'b0;
        end
        else
        begin
            o_edge <= 1'b0;
            if (i_tick)
            begin
                shift_q <= {shift_q[`ECFD_FILTER_LEN-2:0], sync2_q};
                level_q <= level_d;
                prev_q  <= level_q;
                case (i_edge_sel)
                    `ECFD_EDGE_RISE: o_edge <= level_q & ~prev_q;
                    `ECFD_EDGE_BOTH: o_edge <= level_q ^ prev_q;
                    default:         o_edge <= ~level_q & prev_q;
                endcase
            end
        end
    end

endmodule // ecfd_edge_detect
`default_nettype wire

// file: hdl/ecfd_channel.sv
// One timer channel as external event counter or frequency divider.
`default_nettype none
`include "ecfd_consts.svh"
module ecfd_channel
    import ecfd_pkg::*;
#(
    parameter logic [1:0] CHANNEL = 2'h0
)
(
    input  wire logic                       i_clk,
    input  wire logic                       i_rst_b,
    input  wire logic                       i_unit_clock_enable_bit,
    input  wire logic [`ECFD_PRESCALE_W-1:0] i_clock_prescale_select_a,
    input  wire logic [`ECFD_PRESCALE_W-1:0] i_clock_prescale_select_b,
    input  wire logic                       i_prescale_wr,
    input  wire ecfd_cfg_t                  i_channel_mode_reg,
    input  wire logic                       i_mode_wr,
    input  wire logic                       i_input_noise_filter_enable,
    input  wire logic                       i_filter_wr,
    input  wire logic [`ECFD_CNT_W-1:0]     i_channel_reload_value,
    input  wire logic                       i_reload_wr,
    input  wire logic                       i_output_value_reg,
    input  wire logic                       i_output_value_wr,
    input  wire logic                       i_output_enable_reg,
    input  wire logic                       i_output_enable_wr,
    input  wire logic                       i_start_trigger_reg,
    input  wire logic                       i_stop_trigger_reg,
    input  wire logic                       i_event_input_pin,
    output logic [`ECFD_CNT_W-1:0]          o_channel_down_counter,
    output logic                            o_channel_active_status,
    output logic                            o_channel_zero_irq,
    output logic                            o_timer_output_pin,
    output logic                            o_timer_output_pin_oe
);

    logic                           unit_en_q;
    logic [`ECFD_PRESCALE_W-1:0]    psel_a_q;
    logic [`ECFD_PRESCALE_W-1:0]    psel_b_q;
    logic [15:0]                    prescale_q;
    logic                           tick;
    ecfd_cfg_t                      cfg_q;
    logic                           filter_q;
    logic [`ECFD_CNT_W-1:0]         reload_q;
    logic                           out_val_q;
    logic                           out_en_q;
    ecfd_state_t                    state_q;
    logic                           edge_det;
    logic                           clr;
    logic                           acc;
    logic                           div_ok;
    logic [`ECFD_CNT_W-1:0]         cnt_mask;
    logic                           toggle;
    logic                           irq_d;
    logic                           start;
    logic                           stop;
    logic                           at_zero;

    // Divider mode exists only on two of the four channels.
    assign div_ok = (CHANNEL == `ECFD_DIV_CH_A) || (CHANNEL == `ECFD_DIV_CH_B);
    // A split channel counts events in its lower 8 bits only.
    assign cnt_mask = cfg_q.split_high ? 16'h00FF : 16'hFFFF;
    assign clr = ~unit_en_q;
    assign acc = unit_en_q;

    // Prescaler tap for a 2^sel divide; returns the tick condition.
    function automatic logic tap_tick(input logic [15:0] cnt,
                                      input logic [`ECFD_PRESCALE_W-1:0] sel);
        logic [15:0] mask;
        mask = 16'hFFFF >> (5'h10 - {1'b0, sel});
        tap_tick = ((cnt & mask) == 16'h0000);
    endfunction

    // ----------------------------------------------------------------
    // Unit enable and prescaler
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            unit_en_q <= 1'b0;
        else
            unit_en_q <= i_unit_clock_enable_bit;
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            psel_a_q   <= '0;
            psel_b_q   <= '0;
            prescale_q <= 16'h0000;
        end
        else if (clr)
        begin
            psel_a_q   <= '0;
            psel_b_q   <= '0;
            prescale_q <= 16'h0000;
        end
        else
        begin
            prescale_q <= prescale_q + 16'h0001;
            if (i_prescale_wr && acc)
            begin
                psel_a_q <= i_clock_prescale_select_a;
                psel_b_q <= i_clock_prescale_select_b;
            end
        end
    end

    // Each channel samples its input on the operating clock it selects.
    assign tick = unit_en_q && (cfg_q.clk_sel ? tap_tick(prescale_q, psel_b_q)
                                              : tap_tick(prescale_q, psel_a_q));

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            cfg_q     <= '{mode: ECFD_MODE_EVENT, default: '0};
            filter_q  <= 1'b0;
            reload_q  <= `ECFD_RELOAD_RST;
            out_val_q <= 1'b0;
            out_en_q  <= 1'b0;
        end
        else if (clr)
        begin
            cfg_q     <= '{mode: ECFD_MODE_EVENT, default: '0};
            filter_q  <= 1'b0;
            reload_q  <= `ECFD_RELOAD_RST;
            out_val_q <= 1'b0;
            out_en_q  <= 1'b0;
        end
        else
        begin
            if (i_mode_wr && acc)
            begin
                cfg_q <= i_channel_mode_reg;
                if (!div_ok)
                    cfg_q.mode <= ECFD_MODE_EVENT;
            end
            if (i_filter_wr && acc)
                filter_q <= i_input_noise_filter_enable;
            // Takes effect only at the next reload point.
            if (i_reload_wr && acc)
                reload_q <= i_channel_reload_value;
            if (i_output_enable_wr && acc)
                out_en_q <= i_output_enable_reg;
            if (i_output_value_wr && acc && !o_channel_active_status)
                out_val_q <= i_output_value_reg;
            else if (toggle)
                out_val_q <= ~out_val_q;
        end
    end

    // ----------------------------------------------------------------
    // Edge detection
    // ----------------------------------------------------------------
    ecfd_edge_detect u_edge
    (
        .i_clk       (i_clk),
        .i_rst_b     (i_rst_b),
        .i_clr       (clr),
        .i_tick      (tick),
        .i_filter_en (filter_q),
        .i_edge_sel  (cfg_q.edge_sel),
        .i_pin       (i_event_input_pin),
        .o_edge      (edge_det)
    );

    // ----------------------------------------------------------------
    // Counting state machine
    // ----------------------------------------------------------------

    assign start   = i_start_trigger_reg && acc;
    assign stop    = i_stop_trigger_reg && acc;
    assign at_zero = ((o_channel_down_counter & cnt_mask) == `ECFD_CNT_ZERO);

    always_comb
    begin
        toggle = 1'b0;
        irq_d  = 1'b0;
        if (!stop && edge_det)
        begin
            case (state_q)
                ECFD_ST_ARMED:
                begin
                    toggle = cfg_q.start_irq_select;
                    irq_d  = cfg_q.start_irq_select;
                end
                ECFD_ST_RUN:
                begin
                    irq_d  = at_zero;
                    toggle = at_zero && (cfg_q.mode == ECFD_MODE_DIVIDER);
                end
                default:
                begin
                    toggle = 1'b0;
                    irq_d  = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_q                 <= ECFD_ST_IDLE;
            o_channel_down_counter  <= `ECFD_CNT_ZERO;
            o_channel_active_status <= 1'b0;
        end
        else if (clr)
        begin
            state_q                 <= ECFD_ST_IDLE;
            o_channel_down_counter  <= `ECFD_CNT_ZERO;
            o_channel_active_status <= 1'b0;
        end
        else if (stop)
        begin
            state_q                 <= ECFD_ST_IDLE;
            o_channel_active_status <= 1'b0;
        end
        else if (start)
        begin
            o_channel_active_status <= 1'b1;
            if (cfg_q.mode == ECFD_MODE_DIVIDER)
                state_q <= ECFD_ST_ARMED;
            else
            begin
                state_q                <= ECFD_ST_RUN;
                o_channel_down_counter <= reload_q & cnt_mask;
            end
        end
        else if (edge_det)
        begin
            case (state_q)
                ECFD_ST_ARMED:
                begin
                    o_channel_down_counter <= reload_q & cnt_mask;
                    state_q                <= ECFD_ST_RUN;
                end
                ECFD_ST_RUN:
                begin
                    // Reload at zero gives reload+1 edges per period.
                    if (at_zero)
                        o_channel_down_counter <= reload_q & cnt_mask;
                    else
                        o_channel_down_counter <= o_channel_down_counter - 16'h0001;
                end
                default:
                    state_q <= ECFD_ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    // Both-edge division comes from the edge detector; output jitter is one tick.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_channel_zero_irq    <= 1'b0;
            o_timer_output_pin    <= 1'b0;
            o_timer_output_pin_oe <= 1'b0;
        end
        else if (clr)
        begin
            o_channel_zero_irq    <= 1'b0;
            o_timer_output_pin    <= 1'b0;
            o_timer_output_pin_oe <= 1'b0;
        end
        else
        begin
            o_channel_zero_irq    <= irq_d && !clr;
            o_timer_output_pin    <= out_val_q;
            o_timer_output_pin_oe <= out_en_q;
        end
    end

endmodule // ecfd_channel
`default_nettype wire

// file: tb/ecfd_edge_source.sv
// External edge source that drives the channel's event input pin.
`default_nettype none
module ecfd_edge_source
(
    input  wire logic i_clk,
    output var logic  o_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    initial o_pin = 1'b0;

    // Gives n rising edges; high and low phases last half clocks each.
    task automatic rises(input int n, input int half);
        repeat (n)
        begin
            @(posedge i_clk);
            o_pin <= 1'b1;
            repeat (half) @(posedge i_clk);
            o_pin <= 1'b0;
            repeat (half - 1) @(posedge i_clk);
        end
    endtask
endmodule // ecfd_edge_source
`default_nettype wire

// file: tb/ecfd_channel_checker.sv
// Concurrent checks on the ports of the event counter and divider channel.
`default_nettype none
`include "ecfd_consts.svh"
module ecfd_channel_checker
(
    input wire logic                   i_clk,
    input wire logic                   i_rst_b,
    input wire logic                   i_unit_clock_enable_bit,
    input wire logic                   i_start_trigger_reg,
    input wire logic                   i_stop_trigger_reg,
    input wire logic [`ECFD_CNT_W-1:0] i_channel_reload_value,
    input wire logic                   i_output_enable_reg,
    input wire logic                   i_output_enable_wr,
    input wire logic [`ECFD_CNT_W-1:0] o_channel_down_counter,
    input wire logic                   o_channel_active_status,
    input wire logic                   o_channel_zero_irq,
    input wire logic                   o_timer_output_pin_oe
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    a_irq_one_cycle: assert property (o_channel_zero_irq |=> !o_channel_zero_irq)
        else $error("zero interrupt lasted more than one cycle");
    a_start_sets_active: assert property (i_start_trigger_reg && !i_stop_trigger_reg
        && i_unit_clock_enable_bit && $past(i_unit_clock_enable_bit)
        |=> ##[0:1] o_channel_active_status) else $error("start did not set active status");
    a_stop_clears_active: assert property (i_stop_trigger_reg
        && i_unit_clock_enable_bit && $past(i_unit_clock_enable_bit)
        |=> ##[0:1] !o_channel_active_status) else $error("stop did not clear active status");
    a_disable_clears_all: assert property (!i_unit_clock_enable_bit ##1
        !i_unit_clock_enable_bit |=> o_channel_down_counter == `ECFD_CNT_ZERO
        && !o_channel_active_status && !o_timer_output_pin_oe)
        else $error("unit disable left state behind");
    a_stopped_count_holds: assert property (!o_channel_active_status
        && i_unit_clock_enable_bit && $past(i_unit_clock_enable_bit)
        && !i_start_trigger_reg && !$past(i_start_trigger_reg)
        |=> $stable(o_channel_down_counter)) else $error("stopped counter changed");
    a_irq_after_reload: assert property (o_channel_zero_irq
        |-> o_channel_down_counter == i_channel_reload_value)
        else $error("interrupt without reload of counter");
    a_count_single_step: assert property (o_channel_active_status
        && $past(o_channel_active_status) && !$stable(o_channel_down_counter)
        |-> o_channel_down_counter == $past(o_channel_down_counter) - 16'h0001
        || o_channel_down_counter == i_channel_reload_value)
        else $error("counter moved by other than one step or reload");
    a_oe_follows_write: assert property (i_output_enable_wr
        && i_unit_clock_enable_bit && $past(i_unit_clock_enable_bit)
        |-> ##[1:3] o_timer_output_pin_oe == i_output_enable_reg)
        else $error("output enable write not applied");
endmodule // ecfd_channel_checker

bind ecfd_channel ecfd_channel_checker u_ecfd_channel_checker (.i_clk, .i_rst_b,
    .i_unit_clock_enable_bit, .i_start_trigger_reg, .i_stop_trigger_reg,
    .i_channel_reload_value, .i_output_enable_reg, .i_output_enable_wr,
    .o_channel_down_counter, .o_channel_active_status, .o_channel_zero_irq,
    .o_timer_output_pin_oe);
`default_nettype wire

// file: tb/ecfd_channel_tb.sv
// Self-checking testbench for the event counter and frequency divider channel.
`default_nettype none
`include "ecfd_consts.svh"
module ecfd_channel_tb
    import ecfd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic            i_clk, i_rst_b, i_unit_clock_enable_bit, i_prescale_wr, i_mode_wr;
    logic            i_input_noise_filter_enable, i_filter_wr, i_reload_wr;
    logic            i_output_enable_reg, i_output_enable_wr, i_start_trigger_reg;
    logic            i_stop_trigger_reg, i_event_input_pin, o_channel_active_status;
    logic            o_channel_zero_irq, o_timer_output_pin, o_timer_output_pin_oe, pin_prev;
    logic [3:0]      i_clock_prescale_select_a, i_clock_prescale_select_b;
    logic [15:0]     i_channel_reload_value, o_channel_down_counter, alt_counter;
    ecfd_cfg_t       i_channel_mode_reg;
    int              fail_count, tests_run, irq_cnt, tog_cnt, t0;

    initial
    begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    ecfd_channel u_ecfd_channel (.i_clk, .i_rst_b, .i_unit_clock_enable_bit,
        .i_clock_prescale_select_a, .i_clock_prescale_select_b, .i_prescale_wr,
        .i_channel_mode_reg, .i_mode_wr, .i_input_noise_filter_enable, .i_filter_wr,
        .i_channel_reload_value, .i_reload_wr, .i_output_value_reg(1'b0),
        .i_output_value_wr(1'b0), .i_output_enable_reg, .i_output_enable_wr,
        .i_start_trigger_reg, .i_stop_trigger_reg, .i_event_input_pin,
        .o_channel_down_counter, .o_channel_active_status, .o_channel_zero_irq,
        .o_timer_output_pin, .o_timer_output_pin_oe);

    // A channel without divider support sees the same stimulus.
    ecfd_channel #(.CHANNEL(2'h1)) u_ecfd_channel_alt (.i_clk, .i_rst_b,
        .i_unit_clock_enable_bit, .i_clock_prescale_select_a, .i_clock_prescale_select_b,
        .i_prescale_wr, .i_channel_mode_reg, .i_mode_wr, .i_input_noise_filter_enable,
        .i_filter_wr, .i_channel_reload_value, .i_reload_wr, .i_output_value_reg(1'b0),
        .i_output_value_wr(1'b0), .i_output_enable_reg, .i_output_enable_wr,
        .i_start_trigger_reg, .i_stop_trigger_reg, .i_event_input_pin,
        .o_channel_down_counter(alt_counter), .o_channel_active_status(),
        .o_channel_zero_irq(), .o_timer_output_pin(), .o_timer_output_pin_oe());

    ecfd_edge_source u_ecfd_edge_source (.i_clk, .o_pin(i_event_input_pin));

    // Counted at the falling edge so the tests never race the rising-edge update.
    always @(negedge i_clk)
    begin
        if (o_channel_zero_irq === 1'b1) irq_cnt++;
        if (o_timer_output_pin !== pin_prev) tog_cnt++;
        pin_prev = o_timer_output_pin;
    end

    // ------------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------------
    task automatic wr(input int k);
        @(posedge i_clk);
        case (k)
            0: i_prescale_wr <= 1'b1;
            1: i_mode_wr <= 1'b1;
            2: i_filter_wr <= 1'b1;
            3: i_reload_wr <= 1'b1;
            4: i_output_enable_wr <= 1'b1;
            5: i_start_trigger_reg <= 1'b1;
            default: i_stop_trigger_reg <= 1'b1;
        endcase
        @(posedge i_clk);
        {i_prescale_wr, i_mode_wr, i_filter_wr, i_reload_wr} <= 4'h0;
        {i_output_enable_wr, i_start_trigger_reg, i_stop_trigger_reg} <= 3'h0;
        repeat (3) @(posedge i_clk);
    endtask

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge i_clk);
        fail_count++;
        stop_test();
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial
    begin
        {i_rst_b, i_unit_clock_enable_bit, i_prescale_wr, i_mode_wr, i_filter_wr} = '0;
        {i_input_noise_filter_enable, i_reload_wr, i_output_enable_reg} = '0;
        {i_output_enable_wr, i_start_trigger_reg, i_stop_trigger_reg, pin_prev} = '0;
        i_clock_prescale_select_a = 4'h0;
        i_clock_prescale_select_b = 4'h1;
        i_channel_reload_value = 16'h0002;
        i_channel_mode_reg = '{ECFD_MODE_EVENT, 1'b0, `ECFD_EDGE_RISE, 1'b0, 1'b0};
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        chk("reset counter", 16'h0000, o_channel_down_counter);
        i_unit_clock_enable_bit <= 1'b1;
        repeat (3) @(posedge i_clk);
        wr(0); wr(1); wr(2); wr(3); wr(4); wr(5);
        chk("active", 16'h0001, o_channel_active_status);
        chk("start load", 16'h0002, o_channel_down_counter);
        u_ecfd_edge_source.rises(1, 12);
        chk("one edge", 16'h0001, o_channel_down_counter);
        i_channel_reload_value <= 16'h0004;
        wr(3);
        u_ecfd_edge_source.rises(1, 12);
        chk("old period", 16'h0000, o_channel_down_counter);
        u_ecfd_edge_source.rises(1, 12);
        chk("new reload", 16'h0004, o_channel_down_counter);
        chk("irq once", 16'h0001, 16'(irq_cnt));
        u_ecfd_edge_source.rises(5, 12);
        chk("irq per five", 16'h0002, 16'(irq_cnt));
        u_ecfd_edge_source.rises(1, 12);
        wr(6);
        u_ecfd_edge_source.rises(2, 12);
        chk("stopped", 16'h0000, o_channel_active_status);
        chk("held count", 16'h0003, o_channel_down_counter);
        $display("test event counter done");
        i_unit_clock_enable_bit <= 1'b0;
        i_channel_reload_value <= 16'h0007;
        repeat (3) @(posedge i_clk);
        chk("off counter", 16'h0000, o_channel_down_counter);
        wr(3); wr(5);
        chk("off active", 16'h0000, o_channel_active_status);
        i_unit_clock_enable_bit <= 1'b1;
        repeat (3) @(posedge i_clk);
        wr(5);
        chk("ignored reload", 16'h0000, o_channel_down_counter);
        wr(6);
        $display("test unit enable done");
        i_channel_mode_reg <= '{ECFD_MODE_DIVIDER, 1'b1, `ECFD_EDGE_RISE, 1'b1, 1'b0};
        i_input_noise_filter_enable <= 1'b1;
        i_channel_reload_value <= 16'h0001;
        i_output_enable_reg <= 1'b1;
        wr(0); wr(1); wr(2); wr(3); wr(4); wr(5);
        chk("armed", 16'h0000, o_channel_down_counter);
        chk("no divider", 16'h0001, alt_counter);
        chk("output enable", 16'h0001, o_timer_output_pin_oe);
        t0 = tog_cnt;
        u_ecfd_edge_source.rises(1, 20);
        chk("first load", 16'h0001, o_channel_down_counter);
        chk("first toggle", 16'h0001, 16'(tog_cnt - t0));
        u_ecfd_edge_source.rises(4, 20);
        chk("single edge", 16'h0003, 16'(tog_cnt - t0));
        chk("divider count", 16'h0001, o_channel_down_counter);
        wr(6);
        i_channel_mode_reg <= '{ECFD_MODE_DIVIDER, 1'b1, `ECFD_EDGE_BOTH, 1'b0, 1'b0};
        wr(1); wr(5);
        t0 = tog_cnt;
        u_ecfd_edge_source.rises(1, 20);
        chk("quiet load", 16'h0000, 16'(tog_cnt - t0));
        u_ecfd_edge_source.rises(2, 20);
        chk("both edges", 16'h0002, 16'(tog_cnt - t0));
        $display("test divider done");
        wr(6);
        i_channel_mode_reg <= '{ECFD_MODE_EVENT, 1'b0, `ECFD_EDGE_FALL, 1'b0, 1'b1};
        i_channel_reload_value <= 16'h0102;
        wr(1); wr(3); wr(5);
        chk("split load", 16'h0002, o_channel_down_counter);
        u_ecfd_edge_source.rises(1, 12);
        chk("falling edge", 16'h0001, o_channel_down_counter);
        i_unit_clock_enable_bit <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk("off enable", 16'h0000, o_timer_output_pin_oe);
        chk("off count", 16'h0000, o_channel_down_counter);
        $display("test split and power off done");
        stop_test();
    end
endmodule // ecfd_channel_tb
`default_nettype wire
